/* File: src/tcc_pkg.sv */
package tcc_pkg;
	localparam int TCC_CHANNELS = 5;
	localparam int TCC_UNITS = 10;
	localparam int TCC_WIDTH = 16;
	localparam int TCC_ADDR_W = 5;
	localparam int TCC_FIRST_SHADOW_CH = 3;
	localparam logic [15:0] TCC_GR_RESET = 16'hFFFF;
	localparam logic [15:0] TCC_SHADOW_RESET = 16'hFFFF;
	// Register indices on the CPU bus
	localparam logic [4:0] TCC_IDX_GR_BASE = 5'h00;
	localparam logic [4:0] TCC_IDX_SHADOW_BASE = 5'h0A;
	localparam logic [4:0] TCC_IDX_IOCTL_BASE = 5'h10;
	localparam logic [4:0] TCC_IDX_FUNC = 5'h15;
	localparam logic [4:0] TCC_IDX_FLAG_BASE = 5'h18;
	// I/O control field: low nibble for A, high nibble for B
	localparam int TCC_IOCTL_B_POS = 4;
	localparam int TCC_IOCTL_FIELD_W = 3;
	localparam logic [1:0] TCC_OUT_NONE = 2'b00;
	localparam logic [1:0] TCC_OUT_LOW = 2'b01;
	localparam logic [1:0] TCC_OUT_HIGH = 2'b10;
	localparam logic [1:0] TCC_OUT_TOGGLE = 2'b11;
	localparam logic [1:0] TCC_EDGE_RISE = 2'b00;
	localparam logic [1:0] TCC_EDGE_FALL = 2'b01;
	localparam logic [7:0] TCC_IOCTL_RESET = 8'h00;
	localparam logic [3:0] TCC_FUNC_RESET = 4'h0;
	typedef struct packed {
		logic capture;
		logic [1:0] sel;
	} tcc_cfg_type;
	typedef struct packed {
		logic [1:0] be;
		logic [15:0] data;
	} tcc_wr_type;
endpackage

/* File: src/tcc_unit.sv */
`timescale 1ns/1ps
module tcc_unit
	import tcc_pkg::*;
#(
	parameter bit HAS_SHADOW = 1'b0
) (
	input wire logic clk, // Timer clock
	input wire logic rst_n, // Async reset
	input wire logic ce, // Clock enable
	input wire logic standby, // Synchronous re-init
	input wire logic [15:0] counter, // Channel counter
	input wire tcc_cfg_type cfg, // Role and edge/output select
	input wire logic pwm, // Channel in a PWM mode
	input wire logic cap_sync, // Synchronised capture pin
	input wire logic shadow_en, // Buffer mode enable
	input wire tcc_wr_type gr_wr, // CPU write to general register
	input wire tcc_wr_type sh_wr, // CPU write to shadow register
	output logic [15:0] gr_r, // General register
	output logic [15:0] sh_r, // Shadow register
	output logic event_pulse, // Match or capture this cycle
	output logic pin_r, // Compare output level
	output logic pin_oe_n_r // Low while driving the pin
);
	logic capture_role;
	logic cap_prev_r;
	logic eq_prev_r;
	logic eq;
	logic match;
	logic cap_edge;
	logic [15:0] gr_nxt;
	logic [15:0] sh_nxt;

	// PWM modes ignore the capture bit of the I/O control setting
	assign capture_role = cfg.capture && !pwm;
	assign eq = (counter == gr_r);
	// Only the first cycle of equality counts, so a stalled counter gives one event
	assign match = !capture_role && eq && !eq_prev_r;
	always_comb begin
		case (cfg.sel)
			TCC_EDGE_RISE: cap_edge = cap_sync && !cap_prev_r;
			TCC_EDGE_FALL: cap_edge = !cap_sync && cap_prev_r;
			default: cap_edge = cap_sync != cap_prev_r;
		endcase
	end
	assign event_pulse = match || (capture_role && cap_edge);

	always_comb begin
		gr_nxt = gr_r;
		if (gr_wr.be[1])
			gr_nxt[15:8] = gr_wr.data[15:8];
		if (gr_wr.be[0])
			gr_nxt[7:0] = gr_wr.data[7:0];
		if (capture_role && cap_edge) begin
			gr_nxt = counter;
		end else if (match && HAS_SHADOW && shadow_en) begin
			gr_nxt = sh_r;
		end
	end

	always_comb begin
		sh_nxt = sh_r;
		if (sh_wr.be[1])
			sh_nxt[15:8] = sh_wr.data[15:8];
		if (sh_wr.be[0])
			sh_nxt[7:0] = sh_wr.data[7:0];
		// Shadow follows the role of its general register
		if (capture_role && cap_edge && shadow_en)
			sh_nxt = gr_r;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gr_r <= TCC_GR_RESET;
			eq_prev_r <= 1'b0;
			cap_prev_r <= 1'b0;
		end else if (ce) begin
			if (standby) begin
				gr_r <= TCC_GR_RESET;
				eq_prev_r <= 1'b0;
				cap_prev_r <= 1'b0;
			end else begin
				gr_r <= gr_nxt;
				eq_prev_r <= eq && !capture_role;
				cap_prev_r <= cap_sync;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sh_r <= TCC_SHADOW_RESET;
		end else if (ce) begin
			if (standby || !HAS_SHADOW)
				sh_r <= TCC_SHADOW_RESET;
			else
				sh_r <= sh_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_r <= 1'b0;
			pin_oe_n_r <= 1'b1;
		end else if (ce) begin
			pin_oe_n_r <= standby || capture_role || pwm || cfg.sel == TCC_OUT_NONE;
			if (standby) begin
				pin_r <= 1'b0;
			end else if (match) begin
				case (cfg.sel)
					TCC_OUT_LOW: pin_r <= 1'b0;
					TCC_OUT_HIGH: pin_r <= 1'b1;
					TCC_OUT_TOGGLE: pin_r <= !pin_r;
					default: pin_r <= pin_r;
				endcase
			end
		end
	end
endmodule

/* File: src/tcc_top.sv */
`timescale 1ns/1ps
// How it works
// - Each of five channels holds two 16-bit general registers, A and B.
// - Each general register is compare or capture, chosen by I/O control.
// - Compare role: equality with the channel counter sets the A/B flag.
// - Compare output enabled: drive the configured level on the pin at match.
// - Capture role: valid edge latches the counter and sets the flag together.
// - I/O control chooses rising, falling or both capture edges.
// - A channel in any PWM mode compares only and never drives its pins; I/O control still sets the output level at match.
// - All general and shadow registers take word or byte accesses.
// - Reset or standby: general registers compare, no output, all ones.
// - Channels 3 and 4 each have shadow registers A and B.
// - Four function control bits enable buffering per register pair.
// - A shadow register takes the role of its general register.
// - Buffered compare: shadow copies into the general register at match.
// - Reset or standby loads every shadow register with all ones.
module tcc_top
	import tcc_pkg::*;
(
	input wire logic REF_CLK, // 40 MHz timer clock
	input wire logic RESETN, // Async reset, active low
	input wire logic CLK_EN, // Freezes all state when low
	input wire logic STANDBY, // Standby entry, re-initialises
	input wire logic [TCC_CHANNELS*TCC_WIDTH-1:0] COUNTERS, // Channel counters
	input wire logic [TCC_CHANNELS-1:0] PWM_MODE, // Channel runs a PWM mode
	input wire logic [TCC_UNITS-1:0] TIOC_IN, // Pin levels, A then B per channel
	output logic [TCC_UNITS-1:0] TIOC_OUT, // Compare output levels
	output logic [TCC_UNITS-1:0] TIOC_OE_N, // Low while driving
	output logic [TCC_UNITS-1:0] FLAG_SET, // Match/capture event pulses
	input wire logic [TCC_ADDR_W-1:0] BUS_ADDR, // Register index
	input wire logic BUS_WE, // Write strobe
	input wire logic [1:0] BUS_BE, // Byte enables, 1 upper, 0 lower
	input wire logic [15:0] BUS_WDATA, // Write data
	output logic [15:0] BUS_RDATA // Read data, one cycle after address
);
	logic [TCC_UNITS-1:0] sync1_r;
	logic [TCC_UNITS-1:0] sync2_r;
	logic [15:0] gr_val [TCC_UNITS];
	logic [15:0] sh_val [TCC_UNITS];
	logic [TCC_UNITS-1:0] ev;
	logic [7:0] ioctl_r [TCC_CHANNELS];
	logic [3:0] func_r;
	logic [1:0] flag_r [TCC_CHANNELS];
	logic [15:0] rdata_nxt;
	logic [15:0] rdata_r;

	// Pins are asynchronous to the timer clock
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else if (CLK_EN) begin
			sync1_r <= TIOC_IN;
			sync2_r <= sync1_r;
		end
	end

	genvar i;
	generate
		for (i = 0; i < TCC_UNITS; i++) begin : g_unit
			localparam int CH = i / 2;
			localparam int AB = i % 2;
			localparam bit SH = CH >= TCC_FIRST_SHADOW_CH;
			localparam logic [4:0] GR_IDX = TCC_IDX_GR_BASE + 5'(i);
			localparam logic [4:0] SH_IDX = TCC_IDX_SHADOW_BASE
				+ 5'((i - 2 * TCC_FIRST_SHADOW_CH) & 3);
			tcc_cfg_type cfg;
			tcc_wr_type gr_wr;
			tcc_wr_type sh_wr;
			logic sh_en;
			assign cfg = ioctl_r[CH][AB*TCC_IOCTL_B_POS +: TCC_IOCTL_FIELD_W];
			assign gr_wr.be = (BUS_WE && BUS_ADDR == GR_IDX) ? BUS_BE : 2'b00;
			assign gr_wr.data = BUS_WDATA;
			assign sh_wr.be = (SH && BUS_WE && BUS_ADDR == SH_IDX) ? BUS_BE : 2'b00;
			assign sh_wr.data = BUS_WDATA;
			assign sh_en = SH && func_r[(i - 2 * TCC_FIRST_SHADOW_CH) & 3];
			tcc_unit #(
				.HAS_SHADOW(SH)
			) u_unit (
				.clk(REF_CLK),
				.rst_n(RESETN),
				.ce(CLK_EN),
				.standby(STANDBY),
				.counter(COUNTERS[CH*TCC_WIDTH +: TCC_WIDTH]),
				.cfg(cfg),
				.pwm(PWM_MODE[CH]),
				.cap_sync(sync2_r[i]),
				.shadow_en(sh_en),
				.gr_wr(gr_wr),
				.sh_wr(sh_wr),
				.gr_r(gr_val[i]),
				.sh_r(sh_val[i]),
				.event_pulse(ev[i]),
				.pin_r(TIOC_OUT[i]),
				.pin_oe_n_r(TIOC_OE_N[i])
			);
		end
	endgenerate

	assign FLAG_SET = ev & {TCC_UNITS{CLK_EN}};

	genvar c;
	generate
		for (c = 0; c < TCC_CHANNELS; c++) begin : g_chan
			localparam logic [4:0] IO_IDX = TCC_IDX_IOCTL_BASE + 5'(c);
			localparam logic [4:0] FL_IDX = TCC_IDX_FLAG_BASE + 5'(c);
			always_ff @(posedge REF_CLK or negedge RESETN) begin
				if (!RESETN) begin
					ioctl_r[c] <= TCC_IOCTL_RESET;
				end else if (CLK_EN) begin
					if (STANDBY)
						ioctl_r[c] <= TCC_IOCTL_RESET;
					else if (BUS_WE && BUS_BE[0] && BUS_ADDR == IO_IDX)
						ioctl_r[c] <= BUS_WDATA[7:0];
				end
			end
			// Write one to clear; a new event in the same cycle wins
			always_ff @(posedge REF_CLK or negedge RESETN) begin
				if (!RESETN) begin
					flag_r[c] <= 2'b00;
				end else if (CLK_EN) begin
					if (STANDBY)
						flag_r[c] <= 2'b00;
					else if (BUS_WE && BUS_BE[0] && BUS_ADDR == FL_IDX)
						flag_r[c] <= (flag_r[c] & ~BUS_WDATA[1:0]) | ev[2*c +: 2];
					else
						flag_r[c] <= flag_r[c] | ev[2*c +: 2];
				end
			end
		end
	endgenerate

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			func_r <= TCC_FUNC_RESET;
		end else if (CLK_EN) begin
			if (STANDBY)
				func_r <= TCC_FUNC_RESET;
			else if (BUS_WE && BUS_BE[0] && BUS_ADDR == TCC_IDX_FUNC)
				func_r <= BUS_WDATA[3:0];
		end
	end

	always_comb begin
		rdata_nxt = '0;
		for (int k = 0; k < TCC_UNITS; k++) begin
			if (BUS_ADDR == TCC_IDX_GR_BASE + 5'(k))
				rdata_nxt = gr_val[k];
		end
		for (int k = 0; k < 4; k++) begin
			if (BUS_ADDR == TCC_IDX_SHADOW_BASE + 5'(k))
				rdata_nxt = sh_val[2 * TCC_FIRST_SHADOW_CH + k];
		end
		for (int k = 0; k < TCC_CHANNELS; k++) begin
			if (BUS_ADDR == TCC_IDX_IOCTL_BASE + 5'(k))
				rdata_nxt = {8'h00, ioctl_r[k]};
			if (BUS_ADDR == TCC_IDX_FLAG_BASE + 5'(k))
				rdata_nxt = {14'h0000, flag_r[k]};
		end
		if (BUS_ADDR == TCC_IDX_FUNC)
			rdata_nxt = {12'h000, func_r};
	end

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN)
			rdata_r <= '0;
		else if (CLK_EN)
			rdata_r <= rdata_nxt;
	end
	assign BUS_RDATA = rdata_r;
endmodule

/* File: verif/tcc_pins_model.sv */
`timescale 1ns/1ps
module tcc_pins_model
	import tcc_pkg::*;
(
	input wire logic clk, // Timer clock
	input wire logic [TCC_UNITS-1:0] level_cmd, // Requested pin levels
	output logic [TCC_UNITS-1:0] pins // Capture pins into the timer
);
	// Source moves away from the sampling edge, like a slow external signal
	initial pins = '0;
	always @(negedge clk) pins <= level_cmd;
endmodule

/* File: verif/tcc_top_sva.sv */
`timescale 1ns/1ps
module tcc_top_sva
	import tcc_pkg::*;
(
	input wire logic REF_CLK, // Timer clock
	input wire logic RESETN, // Async reset
	input wire logic CLK_EN, // Run enable
	input wire logic STANDBY, // Standby entry
	input wire logic [TCC_CHANNELS-1:0] PWM_MODE, // PWM per channel
	input wire logic [TCC_UNITS-1:0] TIOC_OUT, // Pin levels
	input wire logic [TCC_UNITS-1:0] TIOC_OE_N, // Pin enables
	input wire logic [TCC_UNITS-1:0] FLAG_SET, // Event pulses
	input wire logic [TCC_ADDR_W-1:0] BUS_ADDR, // Index
	input wire logic BUS_WE, // Write strobe
	input wire logic [15:0] BUS_RDATA // Read data
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESETN);
	property p_sb_oe; STANDBY && CLK_EN |=> TIOC_OE_N == '1; endproperty
	a_sb_oe: assert property (p_sb_oe) else $error("pin driven after standby");
	property p_sb_out; STANDBY && CLK_EN |=> TIOC_OUT == '0; endproperty
	a_sb_out: assert property (p_sb_out) else $error("pin level after standby");
	property p_sb_rd;
		(STANDBY && CLK_EN) ##1 (CLK_EN && !BUS_WE && BUS_ADDR < 5'h0E)
		|=> BUS_RDATA == 16'hFFFF;
	endproperty
	a_sb_rd: assert property (p_sb_rd) else $error("register not all ones");
	property p_pwm; (PWM_MODE[0] && CLK_EN) [*2] |-> TIOC_OE_N[1:0] == 2'b11; endproperty
	a_pwm: assert property (p_pwm) else $error("pin driven in pwm mode");
	property p_frz_flag; !CLK_EN |-> FLAG_SET == '0; endproperty
	a_frz_flag: assert property (p_frz_flag) else $error("event while frozen");
	property p_pulse; FLAG_SET[0] |=> !FLAG_SET[0]; endproperty
	a_pulse: assert property (p_pulse) else $error("event longer than one cycle");
	property p_frz_pin; !CLK_EN |=> $stable(TIOC_OE_N) && $stable(TIOC_OUT); endproperty
	a_frz_pin: assert property (p_frz_pin) else $error("pin moved while frozen");
	property p_unmap; CLK_EN && BUS_ADDR == 5'h1F |=> BUS_RDATA == 16'h0000; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule
bind tcc_top tcc_top_sva u_sva (.REF_CLK, .RESETN, .CLK_EN, .STANDBY, .PWM_MODE, .TIOC_OUT,
	.TIOC_OE_N, .FLAG_SET, .BUS_ADDR, .BUS_WE, .BUS_RDATA);

/* File: verif/tcc_top_tb_top.sv */
`timescale 1ns/1ps
module tcc_top_tb_top;
	import tcc_pkg::*;
	logic ref_clk, resetn, clk_en, standby, bus_we;
	logic [79:0] cnt;
	logic [4:0] pwm, bus_addr;
	logic [9:0] lvl, tioc_in, tioc_out, tioc_oe_n, flag_set;
	logic [1:0] bus_be;
	logic [15:0] bus_wdata, bus_rdata;
	int fail_count, n_tests, n_cap, i;
	tcc_top dut (.REF_CLK(ref_clk), .RESETN(resetn), .CLK_EN(clk_en), .STANDBY(standby),
		.COUNTERS(cnt), .PWM_MODE(pwm), .TIOC_IN(tioc_in), .TIOC_OUT(tioc_out),
		.TIOC_OE_N(tioc_oe_n), .FLAG_SET(flag_set), .BUS_ADDR(bus_addr), .BUS_WE(bus_we),
		.BUS_BE(bus_be), .BUS_WDATA(bus_wdata), .BUS_RDATA(bus_rdata));
	tcc_pins_model pins (.clk(ref_clk), .level_cmd(lvl), .pins(tioc_in));
	initial begin
		ref_clk = 0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(negedge ref_clk) if (flag_set[2] === 1'b1) n_cap++;
	task check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr(input logic [4:0] a, input logic [1:0] be, input logic [15:0] d);
		@(negedge ref_clk);
		bus_addr = a;
		bus_be = be;
		bus_wdata = d;
		bus_we = 1;
		@(negedge ref_clk);
		bus_we = 0;
	endtask
	task rd_chk(input logic [4:0] a, input logic [15:0] exp);
		@(negedge ref_clk);
		bus_addr = a;
		@(negedge ref_clk);
		check(bus_rdata, exp);
	endtask
	task complete_run;
		$display("Counts: %0d compared, %0d failed", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task wait_flag(input int u);
		int k;
		k = 0;
		while (k < 12 && flag_set[u] !== 1'b1) begin
			@(negedge ref_clk);
			k++;
		end
		check(flag_set[u], 1'b1);
		if (flag_set[u] !== 1'b1) complete_run;
	endtask
	initial begin
		resetn = 0;
		clk_en = 1;
		standby = 0;
		bus_we = 0;
		cnt = '0;
		pwm = '0;
		lvl = '0;
		bus_addr = '0;
		bus_be = '0;
		bus_wdata = '0;
		repeat (2) @(negedge ref_clk);
		resetn = 1;
		for (i = 0; i < 14; i++) rd_chk(i[4:0], 16'hFFFF);
		for (i = 0; i < 14; i++) wr(i[4:0], 2'b11, 16'h1000 | i[15:0]);
		for (i = 0; i < 14; i++) rd_chk(i[4:0], 16'h1000 | i[15:0]);
		wr(5'h03, 2'b10, 16'hAB00);
		wr(5'h03, 2'b01, 16'h00CD);
		rd_chk(5'h03, 16'hABCD);
		wr(5'h1F, 2'b11, 16'h1234);
		rd_chk(5'h1F, 16'h0000);
		$display("Test bus access done");
		wr(5'h00, 2'b11, 16'h0010);
		wr(5'h10, 2'b11, 16'h0002);
		@(negedge ref_clk);
		cnt[15:0] = 16'h0010;
		#1 check(flag_set[0], 1'b1);
		@(negedge ref_clk);
		check({tioc_oe_n[0], tioc_out[0]}, 16'h0001);
		clk_en = 0;
		repeat (3) @(negedge ref_clk);
		clk_en = 1;
		pwm[0] = 1;
		repeat (2) @(negedge ref_clk);
		check(tioc_oe_n[0], 1'b1);
		pwm[0] = 0;
		wr(5'h06, 2'b11, 16'h0020);
		wr(5'h0A, 2'b11, 16'h0123);
		wr(5'h15, 2'b11, 16'h0001);
		cnt[63:48] = 16'h0020;
		repeat (2) @(negedge ref_clk);
		rd_chk(5'h06, 16'h0123);
		rd_chk(5'h18, 16'h0001);
		wr(5'h18, 2'b01, 16'h0001);
		rd_chk(5'h18, 16'h0000);
		// Low first, then toggle, so each mode moves the pin
		for (i = 1; i < 4; i += 2) begin
			wr(5'h10, 2'b11, i[15:0]);
			cnt[15:0] = 16'h0000;
			@(negedge ref_clk);
			cnt[15:0] = 16'h0010;
			@(negedge ref_clk);
			check(tioc_out[0], (i == 1) ? 1'b0 : 1'b1);
		end
		rd_chk(5'h18, 16'h0001);
		$display("Test compare done");
		wr(5'h13, 2'b11, 16'h0004);
		cnt[63:48] = 16'h0555;
		lvl[6] = 1;
		wait_flag(6);
		rd_chk(5'h06, 16'h0555);
		rd_chk(5'h0A, 16'h0123);
		for (i = 0; i < 3; i++) begin
			wr(5'h11, 2'b11, 16'h0004 + i[15:0]);
			n_cap = 0;
			lvl[2] = 1;
			repeat (8) @(negedge ref_clk);
			lvl[2] = 0;
			repeat (8) @(negedge ref_clk);
			check(n_cap[15:0], (i == 2) ? 16'h0002 : 16'h0001);
		end
		$display("Test capture done");
		standby = 1;
		@(negedge ref_clk);
		standby = 0;
		bus_addr = 5'h0A;
		check(tioc_oe_n, 16'h03FF);
		rd_chk(5'h0A, 16'hFFFF);
		rd_chk(5'h00, 16'hFFFF);
		$display("Test standby done");
		complete_run;
	end
endmodule
